/* File: include/reg_chain_pkg.sv */
// Purpose: shared constants for the register-chain bus master
// Assumes: single 10 MHz clock shared with the peripheral chain
// Notes:   widths and counts fixed by the bus definition
package reg_chain_pkg;
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 32;
    localparam int          SPLIT_HALF_W  = 5;
    // processor cycles a request may wait for an acknowledge
    localparam int          TIMEOUT_CYC   = 64;
    localparam int          TIMER_W       = 6;
    localparam logic [5:0]  TIMER_LAST    = 6'(TIMEOUT_CYC - 1);
    // clock period, for reference when reading waveforms
    localparam int          CLK_PERIOD_NS = 100;
    localparam logic [31:0] WDATA_RESET   = 32'h0000_0000;
    localparam logic [31:0] WDATA_READ    = 32'h0000_0000;
    localparam logic [9:0]  ADDR_RESET    = 10'h000;

    typedef enum logic [2:0] {
        IDLE_S,
        ADDR_S,
        REQ_S,
        HOLD_S
    } master_state_t;

    // split number field holds the two halves of the number swapped
    function automatic logic [ADDR_W-1:0] unsplit_number(
        input logic [ADDR_W-1:0] split_field
    );
        unsplit_number = {split_field[SPLIT_HALF_W-1:0],
                          split_field[ADDR_W-1:SPLIT_HALF_W]};
    endfunction : unsplit_number
endpackage : reg_chain_pkg

/* File: design/access_timer.sv */
// Purpose: counts request cycles for the access timeout
// Assumes: clear_in and run_in never high together
// Notes:   expired_out is high in the last allowed request cycle
`timescale 1ns/10ps
module access_timer
    import reg_chain_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    // control
    input  wire logic              clear_in,
    input  wire logic              run_in,
    // status
    output logic                   expired_out
);
    logic [TIMER_W-1:0] count_q;
    logic [TIMER_W-1:0] count_d;

    assign count_d     = clear_in ? '0 : (run_in ? count_q + 6'h01 : count_q);
    assign expired_out = (count_q == TIMER_LAST);

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_d;
        end
    end
endmodule : access_timer

/* File: design/reg_chain_master.sv */
// Purpose: master end of the device-control register chain bus
// Assumes: chain ack and read data are synchronous to clk_in
// Notes:   works with either ack style and either hard-wired mode
//
// Functional notes
// - 10-bit address out, separate 32-bit write-data out and read-data in.
// - this master alone drives address and separate read and write requests.
// - each access takes at least three cycles, address to handshake end.
// - no ack within 64 request cycles ends the access silently.
// - address is driven one cycle before the request rises.
// - request falls two cycles after the ack is seen high.
// - request is withdrawn only on ack or timeout.
// - both requests stay low during reset.
// - write-data bus is zero during reset.
// - address stable per access; new one after ack low one cycle.
// - address carries the plain register number, not the split field.
// - write data on writes, zeros on reads.
// - read data is captured while the ack is high.
// - read and write requests are never high together.
`timescale 1ns/10ps
module reg_chain_master
    import reg_chain_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    // command side
    input  wire logic              cmd_valid_in,
    input  wire logic              cmd_write_in,
    input  wire logic              cmd_split_in,
    input  wire logic [ADDR_W-1:0] cmd_addr_in,
    input  wire logic [DATA_W-1:0] cmd_wdata_in,
    output logic                   cmd_ready_out,
    output logic                   done_out,
    output logic                   timeout_out,
    output logic [DATA_W-1:0]      rdata_out,
    // register chain bus, 10-bit address, split 32-bit data
    output logic                   reg_read_request_out,
    output logic                   reg_write_request_out,
    output logic [ADDR_W-1:0]      reg_address_out,
    output logic [DATA_W-1:0]      reg_write_data_out,
    input  wire logic              reg_access_ack_in,
    input  wire logic [DATA_W-1:0] reg_read_data_in
);
    master_state_t     state_q;
    master_state_t     state_d;
    logic              write_q;
    logic              rd_req_q;
    logic              wr_req_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic              done_q;
    logic              timeout_q;
    logic              ready_q;
    logic              expired;

    wire               can_accept = (state_q == IDLE_S) || (state_q == HOLD_S);
    // a new address only once the ack has been low for a whole cycle
    wire               take_cmd   = can_accept && ready_q && cmd_valid_in
                                    && !reg_access_ack_in;
    wire               acked      = (state_q == REQ_S) && reg_access_ack_in;
    wire               timed_out  = (state_q == REQ_S) && !reg_access_ack_in && expired;
    wire [ADDR_W-1:0]  plain_addr = cmd_split_in ? unsplit_number(cmd_addr_in) : cmd_addr_in;
    wire               req_any_d  = (state_d == REQ_S) || (state_d == HOLD_S);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            IDLE_S:
            begin
                if (take_cmd)
                    state_d = ADDR_S;
            end
            ADDR_S:
            begin
                state_d = REQ_S;
            end
            // only ack or timeout ends it
            REQ_S:
            begin
                if (acked)
                    state_d = HOLD_S;
                else if (timed_out)
                    state_d = IDLE_S;
            end
            HOLD_S:
            begin
                state_d = take_cmd ? ADDR_S : IDLE_S;
            end
            default:
            begin
                state_d = IDLE_S;
            end
        endcase
    end

    access_timer u_timer (
        .clk_in      (clk_in),
        .arst_n_in   (arst_n_in),
        .clear_in    (state_q != REQ_S),
        .run_in      (state_q == REQ_S),
        .expired_out (expired)
    );

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q  <= IDLE_S;
            rd_req_q <= 1'b0;
            wr_req_q <= 1'b0;
            ready_q  <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            rd_req_q <= req_any_d && !(take_cmd ? cmd_write_in : write_q);
            wr_req_q <= req_any_d && (take_cmd ? cmd_write_in : write_q);
            ready_q  <= (state_d == IDLE_S) || (state_d == HOLD_S);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            write_q <= 1'b0;
            addr_q  <= ADDR_RESET;
            wdata_q <= WDATA_RESET;
        end
        else if (take_cmd)
        begin
            write_q <= cmd_write_in;
            addr_q  <= plain_addr;
            wdata_q <= cmd_write_in ? cmd_wdata_in : WDATA_READ;
        end
        else if (state_d == IDLE_S)
        begin
            wdata_q <= WDATA_RESET;
        end
    end

    // timeout ends quietly apart from a status pulse for the command side
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rdata_q   <= '0;
            done_q    <= 1'b0;
            timeout_q <= 1'b0;
        end
        else
        begin
            done_q    <= acked;
            timeout_q <= timed_out;
            if (acked && !write_q)
                rdata_q <= reg_read_data_in;
        end
    end

    // sole master drives address and requests
    assign cmd_ready_out         = ready_q;
    assign done_out              = done_q;
    assign timeout_out           = timeout_q;
    assign rdata_out             = rdata_q;
    assign reg_read_request_out  = rd_req_q;
    assign reg_write_request_out = wr_req_q;
    assign reg_address_out       = addr_q;
    assign reg_write_data_out    = wdata_q;

    // helper: length of the current request
    wire       req_any = rd_req_q || wr_req_q;
    logic [7:0] req_len_q;
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            req_len_q <= '0;
        else
            req_len_q <= req_any ? req_len_q + 8'h01 : 8'h00;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_req_exclusive: assert property (!(rd_req_q && wr_req_q))
        else $error("read and write requests high together");
    a_req_reset_low: assert property (disable iff (1'b0)
        !arst_n_in |-> !rd_req_q && !wr_req_q)
        else $error("request high during reset");
    a_wdata_reset_zero: assert property (disable iff (1'b0)
        !arst_n_in |-> wdata_q == WDATA_RESET)
        else $error("write data not zero in reset");
    a_addr_leads_req: assert property ($rose(req_any) |->
        $past(state_q == ADDR_S) && $stable(addr_q))
        else $error("request rose without address lead cycle");
    a_min_access: assert property ($rose(req_any) |-> req_any ##1 req_any)
        else $error("access shorter than three cycles");
    a_ack_drop: assert property ((state_q == REQ_S) && reg_access_ack_in |->
        req_any ##1 req_any ##1 !req_any || $rose(req_any))
        else $error("request not dropped two cycles after ack");
    a_no_early_drop: assert property ((state_q == REQ_S) && !reg_access_ack_in
        && !expired |=> req_any)
        else $error("request withdrawn without ack or timeout");
    a_timeout_bound: assert property (req_len_q <= 8'(TIMEOUT_CYC + 1))
        else $error("request outlived the timeout");
    a_addr_stable: assert property (req_any && $past(req_any) &&
        !$rose(req_any) |-> $stable(addr_q))
        else $error("address moved during access");
    a_new_addr_gap: assert property (!$stable(addr_q) |-> $past(!reg_access_ack_in))
        else $error("new address while ack was high");
    a_read_zero: assert property (rd_req_q |-> wdata_q == WDATA_READ)
        else $error("write data not zero on a read");
    a_read_capture: assert property (acked && !write_q |=>
        done_q && rdata_q == $past(reg_read_data_in))
        else $error("read data not captured on ack");

    c_read_done: cover property (rd_req_q && acked ##1 done_q);
    c_write_done: cover property (wr_req_q && acked ##1 done_q);
    c_timeout: cover property (timeout_q);
    c_back_to_back: cover property (done_q ##2 $rose(req_any));
endmodule : reg_chain_master

/* File: sim/periph_chain.sv */
// Purpose: one-register peripheral on the chain facing the master
// Assumes: same clock as the master, latched or one-cycle ack per mode_in
// Notes:   delay_in stretches the ack latency
`timescale 1ns/10ps
module periph_chain
    import reg_chain_pkg::*;
#(
    parameter logic [ADDR_W-1:0] REG_NUM  = 10'h2AA,
    parameter logic [DATA_W-1:0] IMPL_MSK = 32'h0FF0_F0FF
)
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    // bus from master
    input  wire logic              rd_in,
    input  wire logic              wr_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] chain_in,
    // behaviour
    input  wire logic              mode_in,
    input  wire logic [3:0]        delay_in,
    // back to master
    output logic                   ack_out,
    output logic [DATA_W-1:0]      chain_out
);
    logic [DATA_W-1:0] reg_q;
    logic [3:0]        wait_q;
    logic              ack_q;
    logic              done_q;
    wire  logic        sel;
    assign sel = (rd_in | wr_in) && addr_in == REG_NUM;
    assign chain_out = (rd_in && sel) ? (chain_in & ~IMPL_MSK) | (reg_q & IMPL_MSK) : chain_in;
    assign ack_out = ack_q;
    // ack held to request end or dropped after one cycle
    always_ff @(posedge clk_in or negedge arst_n_in)
        if (!arst_n_in)
        begin
            reg_q  <= '0;
            wait_q <= '0;
            ack_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else if (!sel)
        begin
            wait_q <= '0;
            ack_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else if (ack_q)
        begin
            ack_q  <= !mode_in;
            done_q <= 1'b1;
        end
        else if (!done_q && wait_q == delay_in)
        begin
            ack_q <= 1'b1;
            if (wr_in)
                reg_q <= chain_in & IMPL_MSK;
        end
        else if (!done_q)
            wait_q <= wait_q + 4'h1;
endmodule : periph_chain

/* File: sim/control_register_chain_bus_bench.sv */
// Purpose: self-checking bench for the register chain master
// Assumes: one peripheral with one register on the chain
// Notes:   both ack modes, split addressing and timeout
`timescale 1ns/10ps
module control_register_chain_bus_bench;
    import reg_chain_pkg::*;
    localparam logic [DATA_W-1:0] MSK = 32'h0FF0_F0FF;
    logic clk_in = 0, arst_n_in = 1, cmd_valid_in = 0, cmd_write_in = 0, cmd_split_in = 0;
    logic mode_q = 0, got_done, got_to;
    logic [3:0] delay_q = '0;
    logic [ADDR_W-1:0] cmd_addr_in = '0, reg_address_out;
    logic [DATA_W-1:0] cmd_wdata_in = '0, rdata_out, reg_write_data_out, reg_read_data_in;
    logic cmd_ready_out, done_out, timeout_out, reg_access_ack_in;
    logic reg_read_request_out, reg_write_request_out;
    int n_errors = 0, check_count = 0, cycles = 0, n_req;
    always #50 clk_in = ~clk_in;
    reg_chain_master u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
        .cmd_split_in(cmd_split_in), .cmd_addr_in(cmd_addr_in),
        .cmd_wdata_in(cmd_wdata_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
        .timeout_out(timeout_out), .rdata_out(rdata_out),
        .reg_read_request_out(reg_read_request_out),
        .reg_write_request_out(reg_write_request_out), .reg_address_out(reg_address_out),
        .reg_write_data_out(reg_write_data_out), .reg_access_ack_in(reg_access_ack_in),
        .reg_read_data_in(reg_read_data_in));
    periph_chain #(.REG_NUM(10'h2AA), .IMPL_MSK(MSK)) u_chain (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .rd_in(reg_read_request_out), .wr_in(reg_write_request_out),
        .addr_in(reg_address_out), .chain_in(reg_write_data_out), .mode_in(mode_q),
        .delay_in(delay_q), .ack_out(reg_access_ack_in), .chain_out(reg_read_data_in));
    task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // one command, watching the bus until done or timeout
    task automatic access(input logic wr, sp, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] ea, prev_a;
        int k;
        ea = sp ? {a[4:0], a[9:5]} : a;
        n_req = 0;
        got_done = 0;
        got_to = 0;
        k = 0;
        @(posedge clk_in);
        cmd_valid_in <= 1'b1;
        cmd_write_in <= wr;
        cmd_split_in <= sp;
        cmd_addr_in  <= a;
        cmd_wdata_in <= d;
        // look mid-cycle, away from the edge that launches the outputs
        do
            @(negedge clk_in);
        while (!(cmd_ready_out === 1'b1 && reg_access_ack_in === 1'b0) && ++k < 20);
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
        for (k = 0; k < 80 && !got_done && !got_to; k++)
        begin
            @(negedge clk_in);
            got_done = done_out === 1'b1;
            got_to = timeout_out === 1'b1;
            if (reg_read_request_out === 1'b1 || reg_write_request_out === 1'b1)
            begin
                n_req++;
                check("both requests", 32'(reg_read_request_out & reg_write_request_out), 0);
                check("read request", 32'(reg_read_request_out), 32'(!wr));
                check("address", 32'(reg_address_out), 32'(ea));
                check("write data", reg_write_data_out, wr ? d : '0);
                if (n_req == 1)
                    check("early address", 32'(prev_a), 32'(ea));
            end
            prev_a = reg_address_out;
        end
    endtask : access
    task automatic test_reset();
        check("reset write data", reg_write_data_out, '0);
        check("reset requests", 32'(reg_read_request_out | reg_write_request_out), 0);
        check("reset ready", 32'(cmd_ready_out), 0);
        check("reset address", 32'(reg_address_out), 32'(ADDR_RESET));
    endtask : test_reset
    task automatic test_write_read(input logic m, input logic [3:0] dl, input logic sp,
                                   input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        mode_q <= m;
        delay_q <= dl;
        access(1'b1, sp, a, d);
        check("write done", 32'(got_done), 1);
        check("write length", 32'(n_req), 32'(dl) + 3);
        access(1'b0, 1'b0, 10'h2AA, '0);
        check("read data", rdata_out, d & MSK);
        check("read length", 32'(n_req), 32'(dl) + 3);
    endtask : test_write_read
    task automatic test_timeout();
        access(1'b0, 1'b0, 10'h001, '0);
        check("timeout seen", 32'(got_to), 1);
        check("timeout length", 32'(n_req), 64);
        access(1'b0, 1'b0, 10'h2AA, '0);
        check("after timeout", 32'(got_done), 1);
    endtask : test_timeout
    // hang guard: tests need a little over a hundred cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            final_report();
        end
    end
    initial
    begin
        // a real falling edge so the async resets fire at time zero
        arst_n_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        test_reset();
        arst_n_in <= 1'b1;
        test_write_read(1'b0, 4'h0, 1'b0, 10'h2AA, 32'hA5A5_5A5A);
        test_write_read(1'b1, 4'h2, 1'b1, 10'h155, 32'h1234_5678);
        test_timeout();
        final_report();
    end
endmodule : control_register_chain_bus_bench
